// file: design/irm_defs.vh
// irm_defs.vh: constants of the dual-core interrupt, reset and mode-select unit
// assumes a 32-bit classic wishbone slave with byte addresses; included by bare name
//
// Overview of operation
// - the two user interrupts of each core are ranked and each is gated by its mask bit and the core's global disable bit.
// - pending user interrupts sit in a per-core flag register that software polls and clears bit by bit with a one.
// - the non-maskable interrupt is taken whatever the mask register and the global disable bit hold.
// - a non-maskable interrupt sends the core to the vector that belongs to it.
// - while a core's reset input is low the core is halted and its flags, masks and global disable bit return to their reset values.
// - when a core's reset input goes high the core starts fetching at address ff80.
// - a low mode select puts the parallel port in host-port mode.
// - a high mode select puts the parallel port in external-memory mode.
// - the micro mode bit of each core's mode status register is loaded from the mode select level while the core's reset input is low.
`ifndef IRM_DEFS_VH
`define IRM_DEFS_VH

// register byte offsets; core b sits one stride above core a
`define IRM_OFF_FLAG 32'h0000_0000
`define IRM_OFF_MASK 32'h0000_0004
`define IRM_OFF_MODE 32'h0000_0008
`define IRM_CORE_STRIDE 32'h0000_0010
`define IRM_OFF_EVT_STAT 8'h20
`define IRM_OFF_EVT_MASK 8'h24
`define IRM_OFF_PIN_STAT 8'h28

// fields of the mode status register
`define IRM_MODE_GDIS_BIT 0
`define IRM_MODE_MICRO_BIT 1

// event status bits
`define IRM_EVT_A_START 0
`define IRM_EVT_B_START 1
`define IRM_EVT_A_NMI 2
`define IRM_EVT_B_NMI 3
`define IRM_EVT_MODE 4

// reset values
`define IRM_RST_FLAG 2'h0
`define IRM_RST_MASK 2'h0
`define IRM_RST_GDIS 1'h1
`define IRM_RST_EVT 5'h00
// the reset pins start low in the synchroniser, so a device reset takes the
// same path as a core reset pin: the mode bit is loaded and start pulses on release
`define IRM_SYNC_IDLE 9'h13f

// trap source codes, in falling priority
`define IRM_CODE_NMI 2'h0
`define IRM_CODE_INT0 2'h1
`define IRM_CODE_INT1 2'h2

// program addresses
`define IRM_RESET_VECTOR 16'hff80
`define IRM_VEC_NMI 16'hff88
`define IRM_VEC_INT0 16'hffc0
`define IRM_VEC_INT1 16'hffc4

`endif

// file: design/irm_sync.v
// irm_sync.v: two-flop synchroniser for a group of asynchronous pins
// assumes the pins are static levels slower than the clock; idle value given by INIT
`timescale 1ns/1ps
`default_nettype none

module irm_sync #(
    parameter W = 9,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // pins and synchronised levels
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta_q;

    // the first stage feeds only the second stage
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: design/irm_prio.v
// irm_prio.v: picks the trap source of one core
// assumes all inputs are registered state of the same clock
`timescale 1ns/1ps
`default_nettype none
`include "irm_defs.vh"

module irm_prio (
    // pending state
    input wire nmi_pend,
    input wire [1:0] flags,
    input wire [1:0] mask,
    input wire gdis,
    // selection
    output reg req,
    output reg [1:0] sel
);

    wire [1:0] live = flags & mask & {2{~gdis}};

    // nmi ignores mask and global disable; int0 outranks int1
    always @* begin
        req = 1'b1;
        sel = `IRM_CODE_NMI;
        if (nmi_pend) begin
            sel = `IRM_CODE_NMI;
        end else if (live[0]) begin
            sel = `IRM_CODE_INT0;
        end else if (live[1]) begin
            sel = `IRM_CODE_INT1;
        end else begin
            req = 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: design/irm_top.v
// irm_top.v: interrupt, reset and mode-select unit for two cores, with wishbone registers
// assumes pins are asynchronous and active low (mode select excepted); trap ack from
// the core is on CLK
`timescale 1ns/1ps
`default_nettype none
`include "irm_defs.vh"

module irm_top (
    // clock and reset
    input wire CLK,
    input wire NRST,
    // wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output wire IRQ,
    // core a pins
    input wire CORE_A_USER_IRQ_ZERO_N,
    input wire CORE_A_USER_IRQ_ONE_N,
    input wire CORE_A_NMI_N,
    input wire CORE_A_RESET_IN_N,
    // core b pins
    input wire CORE_B_USER_IRQ_ZERO_N,
    input wire CORE_B_USER_IRQ_ONE_N,
    input wire CORE_B_NMI_N,
    input wire CORE_B_RESET_IN_N,
    // mode pin and port personality
    input wire PORT_MODE_SELECT,
    output reg HOST_PORT_MODE,
    output reg EXT_MEMORY_MODE,
    // core a control
    output wire CORE_A_HALT,
    output wire CORE_A_START,
    output wire [15:0] CORE_A_START_ADDR,
    output wire CORE_A_TRAP_REQ,
    output wire [15:0] CORE_A_TRAP_VEC,
    input wire CORE_A_TRAP_ACK,
    output wire CORE_A_MICRO_MODE,
    // core b control
    output wire CORE_B_HALT,
    output wire CORE_B_START,
    output wire [15:0] CORE_B_START_ADDR,
    output wire CORE_B_TRAP_REQ,
    output wire [15:0] CORE_B_TRAP_VEC,
    input wire CORE_B_TRAP_ACK,
    output wire CORE_B_MICRO_MODE
);

    // address match, shared by every register write and core instance
    function hit;
        input [7:0] adr;
        input [7:0] off;
        begin
            hit = (adr[7:2] == off[7:2]);
        end
    endfunction

    // trap vector of a source code
    function [15:0] vec_of;
        input [1:0] code;
        begin
            case (code)
                `IRM_CODE_NMI: vec_of = `IRM_VEC_NMI;
                `IRM_CODE_INT0: vec_of = `IRM_VEC_INT0;
                `IRM_CODE_INT1: vec_of = `IRM_VEC_INT1;
                default: vec_of = `IRM_VEC_NMI;
            endcase
        end
    endfunction

    // synchronised pins; order: irq a0 a1 b0 b1, nmi a b, reset a b, mode
    // the retimed reset bits come up low after a device reset, so both cores
    // sit halted for two edges, load their mode bit and then see a clean rise;
    // this costs two cycles of start-up but gives one release path for both resets
    wire [8:0] pins_s;
    wire [3:0] irq_s = pins_s[3:0];
    wire [1:0] nmi_s = pins_s[5:4];
    wire [1:0] rst_s = pins_s[7:6];
    wire mode_s = pins_s[8];
    wire [1:0] trap_ack = {CORE_B_TRAP_ACK, CORE_A_TRAP_ACK};

    // every async pin is retimed before use; mode select is trusted to move only
    // between bus cycles, so one retimed level is enough for it
    irm_sync #(
        .W(9),
        .INIT(`IRM_SYNC_IDLE)
    ) u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .d({PORT_MODE_SELECT, CORE_B_RESET_IN_N, CORE_A_RESET_IN_N, CORE_B_NMI_N,
            CORE_A_NMI_N, CORE_B_USER_IRQ_ONE_N, CORE_B_USER_IRQ_ZERO_N,
            CORE_A_USER_IRQ_ONE_N, CORE_A_USER_IRQ_ZERO_N}),
        .q(pins_s)
    );

    // bus strobes: ack one cycle after the request, write lands with the ack
    wire bus_req = WB_CYC_I & WB_STB_I;
    wire wr_en = bus_req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];

    // per-core exception logic
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_core
            localparam [31:0] OFF_F = `IRM_OFF_FLAG + c * `IRM_CORE_STRIDE;
            localparam [31:0] OFF_M = `IRM_OFF_MASK + c * `IRM_CORE_STRIDE;
            localparam [31:0] OFF_S = `IRM_OFF_MODE + c * `IRM_CORE_STRIDE;

            reg [1:0] irq_prev_q;
            reg nmi_prev_q;
            reg rst_prev_q;
            reg [1:0] flag_q;
            reg [1:0] mask_q;
            reg gdis_q;
            reg micro_q;
            reg nmi_pend_q;
            reg halt_q;
            reg start_q;
            reg trap_q;
            reg [1:0] code_q;
            reg [15:0] vec_q;
            wire req;
            wire [1:0] sel;

            wire in_rst = ~rst_s[c];
            // pins idle high, so a falling edge is the request
            wire [1:0] irq_edge = irq_prev_q & ~irq_s[2*c+1:2*c];
            wire nmi_edge = nmi_prev_q & ~nmi_s[c];
            wire rst_rise = rst_s[c] & ~rst_prev_q;
            wire taken = trap_q & trap_ack[c];
            wire ack_nmi = taken & (code_q == `IRM_CODE_NMI);
            wire [1:0] ack_irq = {taken & (code_q == `IRM_CODE_INT1),
                                  taken & (code_q == `IRM_CODE_INT0)};
            wire [1:0] w1c = (wr_en && hit(WB_ADR_I, OFF_F[7:0])) ? WB_DAT_I[1:0] : 2'h0;
            wire wr_mask = wr_en && hit(WB_ADR_I, OFF_M[7:0]);
            wire wr_mode = wr_en && hit(WB_ADR_I, OFF_S[7:0]);

            irm_prio u_prio (
                .nmi_pend(nmi_pend_q),
                .flags(flag_q),
                .mask(mask_q),
                .gdis(gdis_q),
                .req(req),
                .sel(sel)
            );

            // flags, masks, status and the trap handshake
            always @(posedge CLK or negedge NRST) begin
                if (!NRST) begin
                    irq_prev_q <= 2'h3;
                    nmi_prev_q <= 1'b1;
                    rst_prev_q <= 1'b1;
                    flag_q <= `IRM_RST_FLAG;
                    mask_q <= `IRM_RST_MASK;
                    gdis_q <= `IRM_RST_GDIS;
                    micro_q <= 1'b0;
                    nmi_pend_q <= 1'b0;
                    halt_q <= 1'b1;
                    start_q <= 1'b0;
                    trap_q <= 1'b0;
                    code_q <= `IRM_CODE_NMI;
                    vec_q <= `IRM_VEC_NMI;
                end else begin
                    irq_prev_q <= irq_s[2*c+1:2*c];
                    nmi_prev_q <= nmi_s[c];
                    rst_prev_q <= rst_s[c];
                    halt_q <= in_rst;
                    start_q <= rst_rise;
                    if (in_rst) begin
                        // core held: state back to reset, mode bit follows the pin
                        flag_q <= `IRM_RST_FLAG;
                        mask_q <= `IRM_RST_MASK;
                        gdis_q <= `IRM_RST_GDIS;
                        micro_q <= mode_s;
                        nmi_pend_q <= 1'b0;
                        trap_q <= 1'b0;
                    end else begin
                        // an edge in the clearing cycle survives
                        flag_q <= (flag_q & ~w1c & ~ack_irq) | irq_edge;
                        nmi_pend_q <= (nmi_pend_q & ~ack_nmi) | nmi_edge;
                        if (wr_mask) begin
                            mask_q <= WB_DAT_I[1:0];
                        end
                        if (wr_mode) begin
                            gdis_q <= WB_DAT_I[`IRM_MODE_GDIS_BIT];
                            micro_q <= WB_DAT_I[`IRM_MODE_MICRO_BIT];
                        end
                        // a presented trap stays until the core takes it
                        if (taken) begin
                            trap_q <= 1'b0;
                            if (code_q != `IRM_CODE_NMI) begin
                                gdis_q <= 1'b1;
                            end
                        end else if (!trap_q && req) begin
                            trap_q <= 1'b1;
                            code_q <= sel;
                            vec_q <= vec_of(sel);
                        end
                    end
                end
            end
        end
    endgenerate

    // core outputs
    // the start address is fixed; a core only samples it with the start pulse
    assign CORE_A_HALT = g_core[0].halt_q;
    assign CORE_A_START = g_core[0].start_q;
    assign CORE_A_START_ADDR = `IRM_RESET_VECTOR;
    assign CORE_A_TRAP_REQ = g_core[0].trap_q;
    assign CORE_A_TRAP_VEC = g_core[0].vec_q;
    assign CORE_A_MICRO_MODE = g_core[0].micro_q;
    assign CORE_B_HALT = g_core[1].halt_q;
    assign CORE_B_START = g_core[1].start_q;
    assign CORE_B_START_ADDR = `IRM_RESET_VECTOR;
    assign CORE_B_TRAP_REQ = g_core[1].trap_q;
    assign CORE_B_TRAP_VEC = g_core[1].vec_q;
    assign CORE_B_MICRO_MODE = g_core[1].micro_q;

    // port personality follows the retimed pin
    // no hold-off here: the board keeps the pin still while a bus cycle runs
    reg mode_prev_q;
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            HOST_PORT_MODE <= 1'b0;
            EXT_MEMORY_MODE <= 1'b1;
            mode_prev_q <= 1'b1;
        end else begin
            HOST_PORT_MODE <= ~mode_s;
            EXT_MEMORY_MODE <= mode_s;
            mode_prev_q <= mode_s;
        end
    end

    // event bits: set beats a same-cycle write-one clear
    reg [4:0] evt_q;
    reg [4:0] evt_mask_q;
    wire [4:0] evt_set;
    assign evt_set[`IRM_EVT_A_START] = g_core[0].rst_rise;
    assign evt_set[`IRM_EVT_B_START] = g_core[1].rst_rise;
    assign evt_set[`IRM_EVT_A_NMI] = g_core[0].nmi_edge & rst_s[0];
    assign evt_set[`IRM_EVT_B_NMI] = g_core[1].nmi_edge & rst_s[1];
    assign evt_set[`IRM_EVT_MODE] = mode_s ^ mode_prev_q;
    wire [4:0] evt_clr = (wr_en && hit(WB_ADR_I, `IRM_OFF_EVT_STAT)) ? WB_DAT_I[4:0] : 5'h00;

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            evt_q <= `IRM_RST_EVT;
            evt_mask_q <= `IRM_RST_EVT;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
            if (wr_en && hit(WB_ADR_I, `IRM_OFF_EVT_MASK)) begin
                evt_mask_q <= WB_DAT_I[4:0];
            end
        end
    end

    assign IRQ = |(evt_q & evt_mask_q);

    // read mux; unmapped addresses read zero and still get their ack
    // only the low bits of each word carry fields, the rest read zero
    // the pin status word shows the retimed levels, not the raw pins, so
    // software sees exactly what the control logic acts on
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0000_0000;
        case (WB_ADR_I[7:2])
            6'h00: rd_d[1:0] = g_core[0].flag_q;
            6'h01: rd_d[1:0] = g_core[0].mask_q;
            6'h02: rd_d[1:0] = {g_core[0].micro_q, g_core[0].gdis_q};
            6'h04: rd_d[1:0] = g_core[1].flag_q;
            6'h05: rd_d[1:0] = g_core[1].mask_q;
            6'h06: rd_d[1:0] = {g_core[1].micro_q, g_core[1].gdis_q};
            6'h08: rd_d[4:0] = evt_q;
            6'h09: rd_d[4:0] = evt_mask_q;
            // pin status: halts above the port mode bit, retimed pins at the bottom
            6'h0a: rd_d[11:0] = {g_core[1].halt_q, g_core[0].halt_q, HOST_PORT_MODE, pins_s};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // ack is registered, so it costs one wait state but keeps timing off the decode
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
            if (bus_req && !WB_ACK_O) begin
                WB_DAT_O <= rd_d;
            end
        end
    end

endmodule

`default_nettype wire

// file: bench/irm_assertions.sv
// irm_assertions.sv: timing checks on core a control, mode and bus ack outputs
// assumes it is bound into irm_top and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module irm_assertions (
    // clock, reset, bus
    input wire logic CLK,
    input wire logic NRST,
    input wire logic WB_ACK_O,
    // core a
    input wire logic CORE_A_RESET_IN_N,
    input wire logic CORE_A_NMI_N,
    input wire logic CORE_A_HALT,
    input wire logic CORE_A_START,
    input wire logic [15:0] CORE_A_START_ADDR,
    input wire logic CORE_A_TRAP_REQ,
    input wire logic CORE_A_TRAP_ACK,
    input wire logic [15:0] CORE_A_TRAP_VEC,
    input wire logic CORE_A_MICRO_MODE,
    // mode pin and outputs
    input wire logic PORT_MODE_SELECT,
    input wire logic HOST_PORT_MODE,
    input wire logic EXT_MEMORY_MODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // nmi edge on an idle, running core; a pending trap would hide it
    sequence nmi_seen;
        $fell(CORE_A_NMI_N) && !CORE_A_TRAP_REQ && !CORE_A_HALT ##1 (!CORE_A_NMI_N)[*4];
    endsequence
    chk_ack_one: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack longer than one cycle");
    chk_halt_on: assert property ((!CORE_A_RESET_IN_N)[*4] |=> CORE_A_HALT)
        else $error("core a not halted in reset");
    chk_start_pulse: assert property (CORE_A_START |-> !CORE_A_HALT && $past(CORE_A_HALT))
        else $error("start without halt release");
    chk_start_fall: assert property ($fell(CORE_A_HALT) |-> CORE_A_START)
        else $error("halt release without start");
    chk_start_addr: assert property (CORE_A_START_ADDR == 16'hff80)
        else $error("wrong start address");
    chk_nmi_trap: assert property (nmi_seen |-> ##[0:3] CORE_A_TRAP_REQ && CORE_A_TRAP_VEC == 16'hff88)
        else $error("nmi not trapped to its vector");
    chk_trap_hold: assert property (CORE_A_TRAP_REQ && !CORE_A_TRAP_ACK |=> CORE_A_TRAP_REQ && $stable(CORE_A_TRAP_VEC))
        else $error("trap withdrawn before ack");
    chk_mode_ext: assert property (PORT_MODE_SELECT[*4] |=> EXT_MEMORY_MODE && !HOST_PORT_MODE)
        else $error("external memory mode not set");
    chk_mode_host: assert property ((!PORT_MODE_SELECT)[*4] |=> HOST_PORT_MODE && !EXT_MEMORY_MODE)
        else $error("host port mode not set");
    chk_micro_load: assert property ((!CORE_A_RESET_IN_N && CORE_A_HALT && $stable(EXT_MEMORY_MODE))[*3] |-> CORE_A_MICRO_MODE == EXT_MEMORY_MODE)
        else $error("micro bit not loaded in reset");
    // main scenarios reached
    cov_start: cover property (CORE_A_START);
    cov_int0: cover property (CORE_A_TRAP_REQ && CORE_A_TRAP_VEC == 16'hffc0);
    cov_host: cover property (HOST_PORT_MODE);
endmodule
`default_nettype wire

// file: bench/irm_pins_model.sv
// irm_pins_model.sv: board pins and core trap acknowledge
// assumes the unit's clock; pins {mode,rstB,rstA,nmiB,nmiA,irqB1,irqB0,irqA1,irqA0}
`timescale 1ns/1ps
`default_nettype none
module irm_pins_model (
    // clock
    input wire logic clk,
    // trap handshake of both cores
    input wire logic [1:0] req,
    output logic [1:0] ack,
    // pins, all active low except mode in bit 8
    output logic [8:0] pins
);
    int dly = 8;
    logic [3:0] cnt [2];
    initial begin
        ack = 2'h0;
        pins = 9'h1ff;
    end
    // slow core: a trap stands dly+2 cycles before it is taken, so the bench can watch it
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= (req[i] && !ack[i]) ? cnt[i] + 4'h1 : 4'h0;
            ack[i] <= req[i] && !ack[i] && cnt[i] >= dly[3:0];
        end
    end
    // drive one pin, then let n cycles pass
    task automatic hold(input int i, input logic v, input int n);
        pins[i] <= v;
        repeat (n) @(posedge clk);
    endtask
    // request edge held long enough for the two-flop sampler on both sides
    task automatic pulse(input int i);
        hold(i, 1'b0, 5);
        hold(i, 1'b1, 5);
    endtask
endmodule
`default_nettype wire

// file: bench/tb_interrupt_reset_mode_select.sv
// tb_interrupt_reset_mode_select.sv: self-checking bench of the interrupt, reset and mode unit
// assumes irm_top, the pin model and the checker; clock 25 MHz
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_reset_mode_select;
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] q;
    int miscompares = 0;
    int num_checks = 0;
    wire logic [31:0] rdat;
    wire logic ack, irq, hpm, emm;
    wire logic [1:0] halt, start, treq, tack, micro;
    wire logic [8:0] pins;
    wire logic [15:0] sa [2];
    wire logic [15:0] vec [2];
    irm_top uut (
        .CLK(CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq),
        .CORE_A_USER_IRQ_ZERO_N(pins[0]), .CORE_A_USER_IRQ_ONE_N(pins[1]),
        .CORE_B_USER_IRQ_ZERO_N(pins[2]), .CORE_B_USER_IRQ_ONE_N(pins[3]),
        .CORE_A_NMI_N(pins[4]), .CORE_B_NMI_N(pins[5]), .CORE_A_RESET_IN_N(pins[6]),
        .CORE_B_RESET_IN_N(pins[7]), .PORT_MODE_SELECT(pins[8]),
        .HOST_PORT_MODE(hpm), .EXT_MEMORY_MODE(emm),
        .CORE_A_HALT(halt[0]), .CORE_A_START(start[0]), .CORE_A_START_ADDR(sa[0]),
        .CORE_A_TRAP_REQ(treq[0]), .CORE_A_TRAP_VEC(vec[0]), .CORE_A_TRAP_ACK(tack[0]),
        .CORE_A_MICRO_MODE(micro[0]),
        .CORE_B_HALT(halt[1]), .CORE_B_START(start[1]), .CORE_B_START_ADDR(sa[1]),
        .CORE_B_TRAP_REQ(treq[1]), .CORE_B_TRAP_VEC(vec[1]), .CORE_B_TRAP_ACK(tack[1]),
        .CORE_B_MICRO_MODE(micro[1])
    );
    irm_pins_model pm (.clk(CLK), .req(treq), .ack(tack), .pins(pins));
    // 40 ns clock
    initial begin
        forever #20 CLK = ~CLK;
    end
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge CLK);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge CLK);
            n++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) chk(32'h0, 32'h1);
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // wait for a trap of core c, compare vector, then wait until it is taken
    task automatic trap(input int c, input logic [15:0] v);
        for (int n = 0; n < 20 && treq[c] !== 1'b1; n++) @(posedge CLK);
        chk({15'h0, treq[c], vec[c]}, {16'h1, v});
        for (int n = 0; n < 20 && treq[c] !== 1'b0; n++) @(posedge CLK);
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge CLK);
        miscompares++;
        print_verdict;
    end
    initial begin
        repeat (6) @(posedge CLK);
        NRST <= 1'b1;
        repeat (6) @(posedge CLK);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h3);
        rd(8'h28, 32'h1ff);
        rd(8'h3c, 32'h0);
        rd(8'h20, 32'h3);
        chk({14'h0, halt, sa[0]}, {16'h0, 16'hff80});
        chk({16'h0, sa[1]}, 32'h0000_ff80);
        wb(1'b1, 8'h24, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h20, 32'h1);
        chk({31'h0, irq}, 32'h0);
        $display("test reset and events done");
        pm.pulse(0);
        pm.pulse(1);
        rd(8'h00, 32'h3);
        chk({31'h0, treq[0]}, 32'h0);
        wb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h2);
        pm.pulse(0);
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b1, 8'h08, 32'h2);
        trap(0, 16'hffc0);
        rd(8'h00, 32'h2);
        rd(8'h08, 32'h3);
        wb(1'b1, 8'h08, 32'h2);
        trap(0, 16'hffc4);
        rd(8'h00, 32'h0);
        $display("test user interrupts done");
        sel <= 4'he;
        wb(1'b1, 8'h04, 32'h0); // lane 0 off, write ignored
        sel <= 4'hf;
        rd(8'h04, 32'h3);
        wb(1'b1, 8'h04, 32'h0);
        pm.pulse(4);
        trap(0, 16'hff88);
        pm.pulse(5);
        trap(1, 16'hff88);
        $display("test nmi done");
        wb(1'b1, 8'h04, 32'h3);
        pm.hold(8, 1'b0, 6); // bus idle while the mode pin moves
        chk({30'h0, hpm, emm}, 32'h2);
        rd(8'h20, 32'h1e);
        pm.hold(6, 1'b0, 6);
        chk({30'h0, halt}, 32'h1);
        rd(8'h28, 32'h6bf);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h1);
        rd(8'h18, 32'h3);
        pm.hold(6, 1'b1, 0);
        for (int n = 0; n < 20 && start[0] !== 1'b1; n++) @(posedge CLK);
        chk({14'h0, start[0], halt[0], sa[0]}, {16'h2, 16'hff80});
        chk({31'h0, irq}, 32'h1); // start event of core a is unmasked
        rd(8'h08, 32'h1);
        pm.hold(8, 1'b1, 6); // bus idle while the mode pin moves
        chk({30'h0, hpm, emm}, 32'h1);
        chk({30'h0, micro}, 32'h2);
        $display("test mode and core reset done");
        print_verdict;
    end
endmodule
bind irm_top irm_assertions chk_i (
    .CLK(CLK), .NRST(NRST), .WB_ACK_O(WB_ACK_O), .CORE_A_RESET_IN_N(CORE_A_RESET_IN_N),
    .CORE_A_NMI_N(CORE_A_NMI_N), .CORE_A_HALT(CORE_A_HALT), .CORE_A_START(CORE_A_START),
    .CORE_A_START_ADDR(CORE_A_START_ADDR), .CORE_A_TRAP_REQ(CORE_A_TRAP_REQ),
    .CORE_A_TRAP_ACK(CORE_A_TRAP_ACK), .CORE_A_TRAP_VEC(CORE_A_TRAP_VEC),
    .CORE_A_MICRO_MODE(CORE_A_MICRO_MODE), .PORT_MODE_SELECT(PORT_MODE_SELECT),
    .HOST_PORT_MODE(HOST_PORT_MODE), .EXT_MEMORY_MODE(EXT_MEMORY_MODE)
);
`default_nettype wire
